// file: design/bsam_pkg.sv
// Constants and types for the boot section address map block
//
// Notes on behaviour
// - Small part: sizes 128..1024 words start 0xF80/0xF00/0xE00/0xC00.
// - Large part: same sizes start 0x1F80..0x1C00; reset vector there.
// - Small part: 0x000-0xBFF readable section, 0xC00-0xFFF halting one.
// - Large part: 0x0000-0x1BFF readable, 0x1C00-0x1FFF halting section.
// - Small part: 12-bit counter, bits 11:5 page, 4:0 word.
// - Small part: page from pointer 12:6, word from pointer 5:1.
// - Large part: 13-bit counter, page pointer 13:7, word 6:1.
// - Counter bit n sits at pointer bit n+1; bit zero unused by erase and write.
// - Page field picks the page that erase or page write acts on.
// - Pointer bits above the page field are ignored.
// - Load reads use pointer bit zero as low/high byte select.
// - Erase or write to readable section sets busy flag, blocks reads.
// - Busy clears on re-enable after programming, or on page load.
package bsam_pkg;

  // Timing: least flash operation time, rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PROG_TIME_NS  = 3700000;
  localparam int unsigned PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // APB register byte offsets
  localparam logic [7:0] OFS_PTR    = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BOUNDS = 8'h0c;
  localparam logic [7:0] OFS_DECODE = 8'h10;

  // Command register bit positions
  localparam int CMD_ERASE_BIT    = 0;
  localparam int CMD_WRITE_BIT    = 1;
  localparam int CMD_LOAD_BIT     = 2;
  localparam int CMD_REENABLE_BIT = 3;

  // Status register bit positions
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_PROG_BIT   = 1;
  localparam int ST_SEL_LSB    = 2;
  localparam int ST_WIDE_BIT   = 4;
  localparam int ST_CFG_BIT    = 5;

  // Decode and bounds register field positions
  localparam int DEC_WORD_LSB  = 8;
  localparam int DEC_BYTE_BIT  = 14;
  localparam int DEC_RWW_BIT   = 15;
  localparam int BND_END_LSB   = 16;

  // Boot section starts, small part
  localparam logic [12:0] BOOT_S_128  = 13'h0f80;
  localparam logic [12:0] BOOT_S_256  = 13'h0f00;
  localparam logic [12:0] BOOT_S_512  = 13'h0e00;
  localparam logic [12:0] BOOT_S_1024 = 13'h0c00;
  // Boot section starts, large part
  localparam logic [12:0] BOOT_L_128  = 13'h1f80;
  localparam logic [12:0] BOOT_L_256  = 13'h1f00;
  localparam logic [12:0] BOOT_L_512  = 13'h1e00;
  localparam logic [12:0] BOOT_L_1024 = 13'h1c00;
  // First word of the halting section
  localparam logic [12:0] HALT_START_S = 13'h0c00;
  localparam logic [12:0] HALT_START_L = 13'h1c00;

  // Reset values
  localparam logic [15:0] PTR_RST      = 16'h0000;
  localparam logic [1:0]  BOOT_SEL_RST = 2'h3;

  typedef enum logic [0:0]
  {
    BSAM_IDLE = 1'b0,
    BSAM_PROG = 1'b1
  } bsam_state_t;

endpackage

// file: design/bsam_section_map.sv
// Boot size select to boot section bounds
`timescale 1ns/1ns
module bsam_section_map
  import bsam_pkg::*;
(
  input  wire logic        wide,        // Large part selected
  input  wire logic [1:0]  sel,         // Boot size select hi/lo
  output logic      [12:0] boot_start,  // First boot word, reset vector
  output logic      [12:0] app_end,     // Last application word
  output logic      [12:0] halt_start   // First halting-section word
);

  // Table lookup; both parts share one shape
  function automatic logic [12:0] start_of(input logic w,
                                           input logic [1:0] s);
    logic [12:0] r;
    r = 13'h0000;
    unique case (s)
      2'h3: r = w ? BOOT_L_128  : BOOT_S_128;
      2'h2: r = w ? BOOT_L_256  : BOOT_S_256;
      2'h1: r = w ? BOOT_L_512  : BOOT_S_512;
      2'h0: r = w ? BOOT_L_1024 : BOOT_S_1024;
    endcase
    return r;
  endfunction

  // Application ends one word below the boot start
  assign boot_start = start_of(wide, sel);
  assign app_end    = boot_start - 13'h0001;
  assign halt_start = wide ? HALT_START_L : HALT_START_S;

endmodule

// file: design/bsam_ptr_split.sv
// Flash pointer to page, word, byte and section fields
`timescale 1ns/1ns
module bsam_ptr_split
#(
  parameter bit WIDE = 1'b0             // Large part when set
)
(
  input  wire logic [15:0] ptr,         // Flash pointer value
  input  wire logic [12:0] halt_start,  // First halting-section word
  output logic      [12:0] word_addr,   // Word address, counter form
  output logic      [6:0]  page,        // Page field
  output logic      [5:0]  word,        // Word-in-page field
  output logic             byte_hi,     // High byte of the word
  output logic             in_rww       // Address in readable section
);

  // Pointer bit zero is the byte select, so counter bit n is pointer n+1;
  // bits above the counter are dropped
  assign word_addr = WIDE ? ptr[13:1]
                          : {1'b0, ptr[12:1]};
  assign page      = WIDE ? word_addr[12:6] : word_addr[11:5];
  assign word      = WIDE ? word_addr[5:0]  : {1'b0, word_addr[4:0]};
  assign byte_hi   = ptr[0];
  assign in_rww    = word_addr < halt_start;

endmodule

// file: design/bsam_top.sv
// Boot section address map with flash command sequencing, APB slave
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module bsam_top
#(
  parameter bit          WIDE      = 1'b0,                  // Large part
  parameter int unsigned PROG_CYC  = bsam_pkg::PROG_CYCLES  // Op length
)
(
  input  wire logic        pclk,             // Core clock, 25 MHz
  input  wire logic        presetn,          // Async reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB access phase
  input  wire logic        pwrite,           // APB write
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error, unmapped
  input  wire logic        boot_size_sel_hi, // Boot size config, high
  input  wire logic        boot_size_sel_lo, // Boot size config, low
  input  wire logic        rd_req,           // Core load request
  input  wire logic [15:0] rd_ptr,           // Pointer for the load
  output logic             rd_grant,         // Load allowed, pulse
  output logic             rd_blocked,       // Load refused, pulse
  output logic      [12:0] rd_word_addr,     // Word to read
  output logic             rd_byte_hi,       // High byte wanted
  output logic             erase_go,         // Page erase start pulse
  output logic             write_go,         // Page write start pulse
  output logic             load_go,          // Buffer load pulse
  output logic      [6:0]  flash_page,       // Page for erase/write
  output logic      [5:0]  flash_word,       // Buffer word for load
  output logic      [15:0] load_data,        // Buffer word data
  output logic             prog_active,      // Flash busy programming
  output logic             section_busy_flag,// Readable section busy
  output logic      [12:0] boot_vector,      // Boot reset address
  output logic      [12:0] app_end           // Last application word
);
  import bsam_pkg::*;

  // Elaboration check: the run timer is 17 bits wide
  if (PROG_CYC < 1 || PROG_CYC >= 131072)
  begin : g_bad_prog_cyc
    $error("PROG_CYC out of range");
  end
  localparam logic [16:0] PROG_LAST = 17'(PROG_CYC - 1);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [15:0]  ptr_ff, load_data_ff;
  logic [1:0]   boot_sel_ff;
  bsam_state_t  state_ff;
  logic [16:0]  timer_ff;
  logic [31:0]  prdata_ff;
  logic         cfg_taken_ff, busy_ff, pready_ff, pslverr_ff;
  logic         rd_grant_ff, rd_blocked_ff, rd_byte_hi_ff;
  logic         erase_go_ff, write_go_ff, load_go_ff;
  logic [12:0]  rd_word_addr_ff, boot_vector_ff, app_end_ff, halt_start_ff;
  logic [6:0]   flash_page_ff;
  logic [5:0]   flash_word_ff;

  // ------------------------------------------------------------------
  // Address maps
  // ------------------------------------------------------------------
  logic [1:0]  map_sel;
  logic [12:0] map_start, map_end, map_halt;
  // Before capture the live pins feed the table
  assign map_sel = cfg_taken_ff ? boot_sel_ff
                                : {boot_size_sel_hi, boot_size_sel_lo};

  bsam_section_map u_map
  (
    .wide       (WIDE),
    .sel        (map_sel),
    .boot_start (map_start),
    .app_end    (map_end),
    .halt_start (map_halt)
  );

  logic [6:0]  cmd_page;
  logic [5:0]  cmd_word;
  logic        cmd_rww;
  // Store side split of the software pointer
  bsam_ptr_split #(.WIDE(WIDE)) u_cmd_split
  (
    .ptr        (ptr_ff),
    .halt_start (halt_start_ff),
    .word_addr  (),
    .page       (cmd_page),
    .word       (cmd_word),
    .byte_hi    (),
    .in_rww     (cmd_rww)
  );

  logic [12:0] rdq_waddr;
  logic        rdq_byte, rdq_rww;
  // Load side split of the core's pointer
  bsam_ptr_split #(.WIDE(WIDE)) u_rd_split
  (
    .ptr        (rd_ptr),
    .halt_start (halt_start_ff),
    .word_addr  (rdq_waddr),
    .page       (),
    .word       (),
    .byte_hi    (rdq_byte),
    .in_rww     (rdq_rww)
  );

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic apb_setup, apb_wr;
  logic hit_ptr, hit_cmd, hit_status, hit_bounds, hit_decode, hit_any;
  // Zero wait states: ready rises in the access cycle
  assign apb_setup  = psel & ~penable;
  assign apb_wr     = psel & penable & pready_ff & pwrite;
  assign hit_ptr    = paddr == OFS_PTR;
  assign hit_cmd    = paddr == OFS_CMD;
  assign hit_status = paddr == OFS_STATUS;
  assign hit_bounds = paddr == OFS_BOUNDS;
  assign hit_decode = paddr == OFS_DECODE;
  assign hit_any    = hit_ptr | hit_cmd | hit_status | hit_bounds |
                      hit_decode;

  logic [31:0] status_word, bounds_word, decode_word, rd_mux;
  // Read views; command register reads as zero
  assign status_word = {26'h0, cfg_taken_ff, WIDE, boot_sel_ff,
                        state_ff == BSAM_PROG, busy_ff};
  assign bounds_word = {3'h0, app_end_ff, 3'h0, boot_vector_ff};
  assign decode_word = {16'h0, cmd_rww, ptr_ff[0], cmd_word,
                        1'b0, cmd_page};
  assign rd_mux = hit_ptr    ? {16'h0, ptr_ff} :
                  hit_status ? status_word :
                  hit_bounds ? bounds_word :
                  hit_decode ? decode_word : 32'h0;

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  logic cmd_wr, idle, start_erase, start_write, start_prog;
  logic do_load, do_reenable, busy_set, busy_clr;
  logic prog_done, nxt_busy;
  // Commands wait for the boot size capture; erase beats write
  assign cmd_wr      = apb_wr & hit_cmd & cfg_taken_ff;
  assign idle        = state_ff == BSAM_IDLE;
  assign start_erase = cmd_wr & idle & pwdata[CMD_ERASE_BIT];
  assign start_write = cmd_wr & idle & ~pwdata[CMD_ERASE_BIT] &
                       pwdata[CMD_WRITE_BIT];
  assign start_prog  = start_erase | start_write;
  // Buffer loads and re-enable are only taken with the flash idle
  assign do_load     = cmd_wr & idle & ~start_prog &
                       pwdata[CMD_LOAD_BIT];
  assign do_reenable = cmd_wr & idle & pwdata[CMD_REENABLE_BIT];
  assign prog_done   = (state_ff == BSAM_PROG) && (timer_ff == 17'h0);

  // Set wins over clear in the same cycle
  assign busy_set = start_prog & cmd_rww;
  assign busy_clr = do_load | do_reenable;
  assign nxt_busy = busy_set | (busy_ff & ~busy_clr);

  // ------------------------------------------------------------------
  // APB response
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end
    else
    begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & ~hit_any;
      if (apb_setup)
        prdata_ff <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // Pointer register; all 16 bits kept, upper ones ignored by the split
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr_ff <= PTR_RST;
    else if (apb_wr && hit_ptr)
      ptr_ff <= pwdata[15:0];
  end

  // ------------------------------------------------------------------
  // Boot size capture
  // ------------------------------------------------------------------
  // One capture after release, so bounds cannot move under running code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_taken_ff   <= 1'b0;
      boot_sel_ff    <= BOOT_SEL_RST;
      boot_vector_ff <= 13'h0;
      app_end_ff     <= 13'h0;
      halt_start_ff  <= 13'h0;
    end
    else if (!cfg_taken_ff)
    begin
      cfg_taken_ff   <= 1'b1;
      boot_sel_ff    <= map_sel;
      boot_vector_ff <= map_start;
      app_end_ff     <= map_end;
      halt_start_ff  <= map_halt;
    end
  end

  // ------------------------------------------------------------------
  // Flash operation sequencer
  // ------------------------------------------------------------------
  // Busy timer models the least programming time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= BSAM_IDLE;
      timer_ff <= 17'h0;
    end
    else
    begin
      unique case (state_ff)
        BSAM_IDLE:
          if (start_prog)
          begin
            state_ff <= BSAM_PROG;
            timer_ff <= PROG_LAST;
          end
        BSAM_PROG:
          if (prog_done)
            state_ff <= BSAM_IDLE;
          else
            timer_ff <= timer_ff - 17'h1;
      endcase
    end
  end

  // Strobes and targets toward the flash array
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erase_go_ff   <= 1'b0;
      write_go_ff   <= 1'b0;
      load_go_ff    <= 1'b0;
      flash_page_ff <= 7'h0;
      flash_word_ff <= 6'h0;
      load_data_ff  <= 16'h0;
      busy_ff       <= 1'b0;
    end
    else
    begin
      erase_go_ff <= start_erase;
      write_go_ff <= start_write;
      load_go_ff  <= do_load;
      busy_ff     <= nxt_busy;
      if (start_prog)
        flash_page_ff <= cmd_page;
      if (do_load)
      begin
        flash_word_ff <= cmd_word;
        load_data_ff  <= pwdata[31:16];
      end
    end
  end

  // ------------------------------------------------------------------
  // Core load path
  // ------------------------------------------------------------------
  // Readable section is fenced while busy; halting section stays open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_grant_ff     <= 1'b0;
      rd_blocked_ff   <= 1'b0;
      rd_word_addr_ff <= 13'h0;
      rd_byte_hi_ff   <= 1'b0;
    end
    else
    begin
      rd_blocked_ff <= rd_req & busy_ff & rdq_rww;
      rd_grant_ff   <= rd_req & ~(busy_ff & rdq_rww);
      if (rd_req)
      begin
        rd_word_addr_ff <= rdq_waddr;
        rd_byte_hi_ff   <= rdq_byte;
      end
    end
  end

  // Outputs
  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign rd_grant          = rd_grant_ff;
  assign rd_blocked        = rd_blocked_ff;
  assign rd_word_addr      = rd_word_addr_ff;
  assign rd_byte_hi        = rd_byte_hi_ff;
  assign erase_go          = erase_go_ff;
  assign write_go          = write_go_ff;
  assign load_go           = load_go_ff;
  assign flash_page        = flash_page_ff;
  assign flash_word        = flash_word_ff;
  assign load_data         = load_data_ff;
  assign prog_active       = state_ff == BSAM_PROG;
  assign section_busy_flag = busy_ff;
  assign boot_vector       = boot_vector_ff;
  assign app_end           = app_end_ff;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Helper: length of the last programming run
  logic [16:0] run_len_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_len_ff <= 17'h0;
    else if (start_prog)
      run_len_ff <= 17'h1;
    else if (state_ff == BSAM_PROG)
      run_len_ff <= run_len_ff + 17'h1;
  end
  sequence s_start_rww;
    start_prog && cmd_rww;
  endsequence
  sequence s_busy_up;
    ##1 section_busy_flag ##1 prog_active;
  endsequence

  a_busy_on_start: assert property (s_start_rww |-> s_busy_up)
    else $error("busy flag not raised by readable-section start");
  a_busy_holds: assert property (
      section_busy_flag && !do_load && !do_reenable |=> section_busy_flag)
    else $error("busy flag dropped without a clearing command");
  a_busy_clears: assert property (
      (do_load || do_reenable) && !busy_set |=> !section_busy_flag)
    else $error("busy flag not cleared by load or re-enable");
  a_read_fenced: assert property (
      rd_req && section_busy_flag && rdq_rww |=> rd_blocked && !rd_grant)
    else $error("read of busy readable section not blocked");
  a_run_length: assert property ($fell(prog_active) |->
      run_len_ff == 17'(PROG_CYC + 1))
    else $error("programming run has wrong length");
  a_page_target: assert property (
      start_prog |=> (erase_go || write_go) && flash_page == $past(cmd_page))
    else $error("page target not taken from pointer");
  a_byte_select: assert property (
      rd_req |=> rd_byte_hi == $past(rd_ptr[0]) &&
      rd_word_addr[0] == $past(rd_ptr[1]))
    else $error("load byte or word select wrong");
  a_bounds_fixed: assert property (
      cfg_taken_ff |=> $stable(boot_vector) && $stable(app_end))
    else $error("boot bounds moved after capture");
  a_app_below: assert property (
      cfg_taken_ff |-> app_end == boot_vector - 13'h0001 &&
      boot_vector[6:0] == 7'h0)
    else $error("application end not one below boot start");
  a_apb_ready: assert property (apb_setup |=> pready ##1 !pready)
    else $error("APB ready not a single access cycle");

endmodule

// file: testbench/bsam_core_model.sv
// Core-side model that issues program-memory loads to the block
`timescale 1ns/1ns
module bsam_core_model
(
  input  wire logic        pclk,         // Core clock
  input  wire logic        rd_grant,     // Load allowed
  input  wire logic        rd_blocked,   // Load refused
  input  wire logic [12:0] rd_word_addr, // Word being read
  input  wire logic        rd_byte_hi,   // High byte wanted
  output logic             rd_req,       // Load request
  output logic      [15:0] rd_ptr        // Load pointer
);
  initial
  begin
    rd_req = 1'b0;
    rd_ptr = 16'h0000;
  end

  // One request cycle; the pointer is inverted after it so stale use shows
  task automatic load(input logic [15:0] p, output logic ok,
                      output logic blk, output logic [12:0] wa,
                      output logic hi);
    @(posedge pclk);
    rd_req <= 1'b1;
    rd_ptr <= p; // Bit zero is the byte select
    @(posedge pclk);
    rd_req <= 1'b0;
    rd_ptr <= ~p;
    // No answer at all is left to the bench timeout
    do
    begin
      @(negedge pclk);
    end
    while (rd_grant !== 1'b1 && rd_blocked !== 1'b1);
    ok = rd_grant;
    blk = rd_blocked;
    wa = rd_word_addr;
    hi = rd_byte_hi;
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the boot section address map block
`timescale 1ns/1ns
module tb;
  import bsam_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, sz_hi, sz_lo, e;
  logic        pready, pslverr, rd_req, rd_grant, rd_blocked, hi, ok, blk;
  logic        rd_byte_hi, erase_go, write_go, load_go, prog_active, busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] rd_ptr, load_data, ld_seen;
  logic [15:0] pt [4] = '{16'hffff, 16'h17fe, 16'h1801, 16'h0041};
  logic [12:0] stt [4] = '{13'hc00, 13'he00, 13'hf00, 13'hf80};
  logic [12:0] rd_word_addr, boot_vector, app_end, wa;
  logic [6:0]  flash_page, pg_seen;
  logic [1:0]  gk_seen;
  logic [5:0]  flash_word, wd_seen;
  int          err_count, cmp_count, cyc;

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  bsam_top #(.WIDE(1'b0), .PROG_CYC(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_size_sel_hi(sz_hi),
    .boot_size_sel_lo(sz_lo), .rd_req(rd_req), .rd_ptr(rd_ptr),
    .rd_grant(rd_grant), .rd_blocked(rd_blocked),
    .rd_word_addr(rd_word_addr), .rd_byte_hi(rd_byte_hi),
    .erase_go(erase_go), .write_go(write_go), .load_go(load_go),
    .flash_page(flash_page), .flash_word(flash_word),
    .load_data(load_data), .prog_active(prog_active),
    .section_busy_flag(busy), .boot_vector(boot_vector), .app_end(app_end));

  bsam_core_model u_core (
    .pclk(pclk), .rd_grant(rd_grant), .rd_blocked(rd_blocked),
    .rd_word_addr(rd_word_addr), .rd_byte_hi(rd_byte_hi),
    .rd_req(rd_req), .rd_ptr(rd_ptr));

  // Catch the one-cycle command pulses, which the APB tasks would miss
  always @(posedge pclk)
  begin
    if (erase_go === 1'b1 || write_go === 1'b1)
      {gk_seen, pg_seen} <= {erase_go, write_go, flash_page};
    if (load_go === 1'b1)
      {ld_seen, wd_seen} <= {load_data, flash_word};
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Bus, reset and compare tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for ready however long; only the bench timeout ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic rst(input logic [1:0] s);
    presetn <= 1'b0;
    {sz_hi, sz_lo} <= s;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask

  // Poll status until the programming run ends; the timeout backs it up
  task automatic idle;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0, r);
    end
    while (r[ST_PROG_BIT] !== 1'b0);
  endtask

  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, sz_hi, sz_lo, presetn} = 6'h0;
    {paddr, pwdata, err_count, cmp_count, cyc} = '0;
    // Every boot size; pins flip after capture and must not matter
    for (int s = 0; s < 4; s++)
    begin
      rst(s[1:0]);
      {sz_hi, sz_lo} <= ~s[1:0];
      apb(1'b0, OFS_BOUNDS, 32'h0, r);
      chk("bounds", {3'h0, stt[s] - 13'h1, 3'h0, stt[s]}, r);
      chk("vector", {3'h0, stt[s] - 13'h1, 3'h0, stt[s]},
          {3'h0, app_end, 3'h0, boot_vector});
      apb(1'b0, OFS_STATUS, 32'h0, r);
      chk("status", {26'h0, 2'b10, s[1:0], 2'b00}, r);
    end
    // Pointer fields, by register and by core load
    foreach (pt[i])
    begin
      apb(1'b1, OFS_PTR, {16'h0, pt[i]}, r);
      apb(1'b0, OFS_DECODE, 32'h0, r);
      chk("decode", {16'h0, pt[i][12:1] < 12'hc00, pt[i][0], 1'b0,
          pt[i][5:1], 1'b0, pt[i][12:6]}, r);
      u_core.load(pt[i], ok, blk, wa, hi);
      chk("rd_addr", {1'b1, pt[i][0], 18'h0, pt[i][12:1]},
          {ok, hi, 17'h0, wa});
    end
    apb(1'b0, 8'h20, 32'h0, r);
    chk("unmapped", 32'h1, {r[30:0], e});
    // Page write to the readable section, word field and bit zero clear
    apb(1'b1, OFS_PTR, 32'h40, r);
    apb(1'b1, OFS_CMD, 32'h2, r);
    apb(1'b0, OFS_STATUS, 32'h0, r);
    chk("busy", 32'h3, {30'h0, r[1:0]});
    chk("busy_pins", 32'h3, {30'h0, prog_active, busy});
    chk("page", {23'h0, 2'b01, 7'h01},
        {23'h0, gk_seen, pg_seen});
    u_core.load(16'h0040, ok, blk, wa, hi);
    chk("blocked", 32'h1, {30'h0, ok, blk});
    u_core.load(16'h1800, ok, blk, wa, hi);
    chk("halt_rd", 32'h2, {30'h0, ok, blk});
    idle();
    chk("busy_hold", 32'h1, {30'h0, r[1:0]});
    apb(1'b1, OFS_CMD, 32'h8, r);
    apb(1'b0, OFS_STATUS, 32'h0, r);
    chk("reenable", 32'h0, {30'h0, r[1:0]});
    // Erase in the halting section leaves the flag clear
    apb(1'b1, OFS_PTR, 32'h1900, r);
    apb(1'b1, OFS_CMD, 32'h1, r);
    apb(1'b0, OFS_STATUS, 32'h0, r);
    chk("halt_busy", 32'h2, {30'h0, r[1:0]});
    chk("page", {23'h0, 2'b10, 7'h64},
        {23'h0, gk_seen, pg_seen});
    idle();
    // Busy again, then a buffer load clears it
    apb(1'b1, OFS_PTR, 32'h0, r);
    apb(1'b1, OFS_CMD, 32'h1, r);
    idle();
    chk("busy_again", 32'h1, {30'h0, r[1:0]});
    apb(1'b1, OFS_PTR, 32'h46, r);
    apb(1'b1, OFS_CMD, 32'hbeef0004, r);
    apb(1'b0, OFS_STATUS, 32'h0, r);
    chk("load", {16'hbeef, 10'h0, 6'h3},
        {ld_seen, 9'h0, r[0], wd_seen});
    end_of_test();
  end
endmodule
